// ==== pbs_pkg.sv ====
package pbs_pkg;
   localparam int unsigned ADDR_W      = 18;
   localparam int unsigned DATA_W      = 18;
   localparam int unsigned LANES       = 2;
   localparam int unsigned LANE_W      = 9;
   localparam int unsigned BURST_W     = 2;
   localparam logic [1:0]  CNT_RST     = 2'h0;
   localparam logic        CYC_RST     = 1'h0;

   typedef enum logic [1:0] {
      PBS_IDLE  = 2'b00,
      PBS_READ  = 2'b01,
      PBS_WRITE = 2'b10
   } pbs_op_e;

   typedef struct packed {
      logic                     proc_strobe_n;
      logic                     ctrl_strobe_n;
      logic                     step_n;
      logic                     cs_primary_n;
      logic                     cs_depth_hi;
      logic                     cs_depth_n;
      logic                     all_lanes_n;
      logic                     lane_qual_n;
      logic [LANES-1:0]         lane_sel_n;
      logic [ADDR_W-1:0]        addr;
   } pbs_ctl_s;
endpackage

// ==== pbs_sram.sv ====
// Function
// [RQ1] Capture every synchronous input on rising clock
// [RQ2] Output enable and sleep act without clock
// [RQ3] Load address only on sampled address strobe
// [RQ4] Internal burst addresses stepped by burst advance
// [RQ5] Two-bit counter seeded from low address bits
// [RQ6] Linear or interleaved order, user selected
// [RQ7] Registered inputs and outputs, pipelined read
// [RQ8] Four-beat burst in 3-1-1-1 pattern
// [RQ9] Self-timed array write after registering inputs
// [RQ10] Byte-lane selects choose written lanes
// [RQ11] Global write low writes all lanes
// [RQ12] Lane selects active low, qualified by enable
// [RQ13] Address taken only with all chip selects
// [RQ14] 18-bit words over common bidirectional bus
// [RQ15] Both strobes low: processor strobe wins
// [RQ16] Processor strobe ignored with primary select high; the code deselects on it instead
// [RQ17] Global write overrides lane selects and enable
// [RQ18] Output enable masked first read after deselect
// [RQ19] Controller holds advance high to hold address
`timescale 1ns/1ps
module pbs_sram
   import pbs_pkg::*;
#(
   parameter int unsigned DEPTH = 262144
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   input  wire pbs_pkg::pbs_ctl_s       ctl,
   input  wire logic                    linear_order,
   input  wire logic                    out_enable_n,
   input  wire logic                    sleep_request,
   input  wire logic [pbs_pkg::DATA_W-1:0] dq_i,
   output logic [pbs_pkg::DATA_W-1:0]   dq_o,
   output logic [pbs_pkg::DATA_W-1:0]   dq_oe
);
   import pbs_pkg::*;

   logic [DATA_W-1:0]  mem [DEPTH];
   pbs_ctl_s           in_q;
   logic [DATA_W-1:0]  din_q;
   logic               sleep_q;
   logic [ADDR_W-1:0]  base_q,  base_d;
   logic [1:0]         seed_q,  seed_d;
   logic [1:0]         cnt_q,   cnt_d;
   logic               sel_q,   sel_d;
   pbs_op_e            op_q,    op_d;
   logic               desel_q, desel_d;
   logic [DATA_W-1:0]  rd_q,    rd_d;
   logic               rdv_q,   rdv_d;
   logic               mask_q,  mask_d;
   logic [ADDR_W-1:0]  nxt_addr;
   logic               chip_on, take_p, take_c, load;
   logic [LANES-1:0]   lane_we;
   logic               wr_now;

   function automatic logic [1:0] next_beat(input logic [1:0] seed, input logic [1:0] cnt,
                                            input logic lin);
      logic [1:0] s;
      s = 2'h0;
      if (lin) begin
         s = cnt + 2'h1;
      end else begin
         s = seed ^ (((seed ^ cnt) + 2'h1) & 2'h3);
      end
      return s;
   endfunction

   // Input registers on the one clock, no reset so data path stays raw
   always_ff @(posedge core_clk) begin
      in_q  <= ctl; // RQ1
      din_q <= dq_i; // RQ1
   end

   // Sleep blocks array reads and writes and the output enable, contents preserved
   assign sleep_q = sleep_request; // RQ2

   assign chip_on = !in_q.cs_primary_n && in_q.cs_depth_hi && !in_q.cs_depth_n; // RQ13
   assign take_p  = !in_q.proc_strobe_n && !in_q.cs_primary_n; // RQ16
   assign take_c  = !in_q.ctrl_strobe_n && in_q.proc_strobe_n; // RQ15
   assign load    = (take_p || take_c) && chip_on; // RQ3
   // Beat address after this edge's step, so each step lands in one cycle
   assign nxt_addr = {base_q[ADDR_W-1:BURST_W], cnt_d}; // RQ5 RQ8

   // Writes recognised only on controller strobe or burst continuation;
   // a processor strobe cycle with all chip selects active is always a read start
   always_comb begin
      lane_we = '0;
      if (!in_q.all_lanes_n) begin
         lane_we = '1; // RQ11 RQ17
      end else if (!in_q.lane_qual_n) begin
         lane_we = ~in_q.lane_sel_n; // RQ10 RQ12
      end
   end
   assign wr_now = (lane_we != '0) && !take_p && !sleep_q;

   always_comb begin
      base_d  = base_q;
      seed_d  = seed_q;
      cnt_d   = cnt_q;
      sel_d   = sel_q;
      op_d    = op_q;
      desel_d = desel_q;
      mask_d  = 1'b0;
      if (load) begin
         base_d  = in_q.addr;
         seed_d  = in_q.addr[1:0]; // RQ5
         cnt_d   = in_q.addr[1:0];
         sel_d   = 1'b1;
         op_d    = (wr_now && take_c) ? PBS_WRITE : PBS_READ;
         mask_d  = desel_q && !(wr_now && take_c); // RQ18
         desel_d = 1'b0;
      end else if ((!in_q.ctrl_strobe_n || (!in_q.proc_strobe_n && in_q.cs_primary_n))
                   && !chip_on) begin
         sel_d   = 1'b0;
         op_d    = PBS_IDLE;
         desel_d = 1'b1;
      end else if (sel_q) begin
         if (!in_q.step_n) begin
            cnt_d = next_beat(seed_q, cnt_q, linear_order); // RQ4 RQ6 RQ19
         end
         op_d = wr_now ? PBS_WRITE : PBS_READ;
      end
   end

   // Self-timed write: array updated on the edge after inputs registered
   always_ff @(posedge core_clk) begin
      if (sel_q && op_d == PBS_WRITE && !load) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_we[i]) begin
               mem[nxt_addr][i*LANE_W +: LANE_W] <= din_q[i*LANE_W +: LANE_W]; // RQ9 RQ14
            end
         end
      end else if (load && op_d == PBS_WRITE) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_we[i]) begin
               mem[in_q.addr][i*LANE_W +: LANE_W] <= din_q[i*LANE_W +: LANE_W]; // RQ9
            end
         end
      end
   end

   always_comb begin
      rdv_d = 1'b0;
      rd_d  = rd_q;
      if (!sleep_q && ((load && op_d == PBS_READ) || (sel_q && !load && op_d == PBS_READ))) begin
         rd_d  = load ? mem[in_q.addr] : mem[nxt_addr]; // RQ7 RQ8
         rdv_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_q  <= '0;
         seed_q  <= CNT_RST;
         cnt_q   <= CNT_RST;
         sel_q   <= CYC_RST;
         op_q    <= PBS_IDLE;
         desel_q <= 1'b1;
         rd_q    <= '0;
         rdv_q   <= 1'b0;
         mask_q  <= 1'b0;
      end else begin
         base_q  <= base_d;
         seed_q  <= seed_d;
         cnt_q   <= cnt_d;
         sel_q   <= sel_d;
         op_q    <= op_d;
         desel_q <= desel_d;
         rd_q    <= rd_d; // RQ7
         rdv_q   <= rdv_d;
         mask_q  <= mask_d;
      end
   end

   // Output stage register; enable itself follows the async pin
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_o <= '0;
      end else begin
         dq_o <= rd_q; // RQ7 RQ8
      end
   end

   // Enable must react without a clock, so it is a gated level here
   logic oe_ok_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_ok_q <= 1'b0;
      end else begin
         oe_ok_q <= rdv_q && !mask_q; // RQ18
      end
   end
   assign dq_oe = {DATA_W{oe_ok_q && !out_enable_n && !sleep_request}}; // RQ2

   read_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      rdv_q |=> (dq_o == $past(rd_q))) else $error("read data not staged"); // RQ7
   load_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (load) |=> (base_q == $past(in_q.addr))) else $error("address not loaded"); // RQ3
   hold_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!load && in_q.step_n) |=> $stable(cnt_q)) else $error("counter moved"); // RQ4
   seed_cnt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      load |=> (cnt_q == $past(in_q.addr[1:0]))) else $error("bad seed"); // RQ5
   proc_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!in_q.proc_strobe_n && in_q.cs_primary_n && in_q.ctrl_strobe_n) |-> !load)
      else $error("strobe used"); // RQ16
   cs_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      load |-> chip_on) else $error("load while deselected"); // RQ13
   gw_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !in_q.all_lanes_n |-> (lane_we == '1)) else $error("global write partial"); // RQ11
   lane_qual_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (in_q.all_lanes_n && in_q.lane_qual_n) |-> (lane_we == '0)) else $error("unqual"); // RQ12
   oe_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (load && desel_q && op_d == PBS_READ) |=> ##1 (oe_ok_q == 1'b0))
      else $error("enable not masked"); // RQ18
endmodule

// ==== pbs_host.sv ====
`timescale 1ns/1ps
module pbs_host (
   input  wire logic                  core_clk,
   output pbs_pkg::pbs_ctl_s          ctl,
   output logic [pbs_pkg::DATA_W-1:0] dq_i
);
   import pbs_pkg::*;
   // Changes 1 ns after the edge, so the whole cycle is stable
   task automatic drive(input logic ps, cs, st, input logic [2:0] ce,
                        input logic [3:0] w, input logic [17:0] a, d);
      @(posedge core_clk);
      #1;
      ctl  = {ps, cs, st, ce, w, a};
      dq_i = d;
   endtask
   // Released data shows the inverse, never the last value
   task automatic idle();
      drive(1'b1, 1'b1, 1'b1, 3'b010, 4'hF, 18'h0, ~dq_i);
   endtask
   initial begin
      ctl  = '1;
      dq_i = '0;
   end
endmodule

// ==== tb_pipelined_sync_burst_sram.sv ====
`timescale 1ns/1ps
module tb_pipelined_sync_burst_sram;
   import pbs_pkg::*;
   logic              core_clk, rst_n, linear_order, out_enable_n, sleep_request;
   pbs_ctl_s          ctl;
   logic [DATA_W-1:0] dq_i, dq_o, dq_oe;
   logic [DATA_W-1:0] mem [4];
   int                miscompares = 0;
   int                compares = 0;
   pbs_sram u_dut (.core_clk(core_clk), .rst_n(rst_n), .ctl(ctl),
      .linear_order(linear_order), .out_enable_n(out_enable_n),
      .sleep_request(sleep_request), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
   pbs_host u_host (.core_clk(core_clk), .ctl(ctl), .dq_i(dq_i));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [17:0] exp, got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [17:0] a, d, input logic [3:0] w, input logic [2:0] ce);
      u_host.drive(1'b1, 1'b0, 1'b1, ce, w, a, d);
      u_host.idle();
   endtask
   // Beats are predicted from the four-word model, not the outputs
   task automatic rd(input logic [17:0] a, input int n, input logic oe);
      for (int k = 0; k < n + 4; k++) begin
         if (k == 0) u_host.drive(1'b0, 1'b1, 1'b1, 3'b010, 4'hF, a, ~a);
         else if (k < n) u_host.drive(1'b1, 1'b1, 1'b0, 3'b010, 4'hF, a, ~a);
         else u_host.idle();
         if (k >= 3 && k < n + 3) begin
            chk("read beat", mem[linear_order ? 2'(a[1:0] + k - 3)
               : 2'(a[1:0] ^ 2'(k - 3))], dq_o);
         end
         if (k == 3) begin
            chk("drive enable", oe ? '1 : '0, dq_oe);
            if (oe) begin
               out_enable_n = 1'b1;
               #1 chk("enable off", '0, dq_oe);
               out_enable_n = 1'b0;
               sleep_request = 1'b1;
               #1 chk("sleep off", '0, dq_oe);
               sleep_request = 1'b0;
            end
         end
      end
   endtask
   initial begin
      rst_n = 1'b0;
      linear_order = 1'b1;
      out_enable_n = 1'b0;
      sleep_request = 1'b0;
      repeat (10) @(posedge core_clk);
      chk("reset data", '0, dq_o);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         mem[i] = 18'h2A5A0 + 18'(i * 18'h04B37);
         wr(18'h01230 + 18'(i), mem[i], 4'h7, 3'b010);
      end
      u_host.drive(1'b1, 1'b0, 1'b1, 3'b000, 4'hF, 18'h0, 18'h0);
      rd(18'h01231, 4, 1'b0);
      linear_order = 1'b0;
      rd(18'h01231, 4, 1'b1);
      wr(18'h01232, 18'h0, 4'hA, 3'b010);
      mem[2][8:0] = 9'h000;
      wr(18'h01232, 18'h3FFFF, 4'hC, 3'b010);
      wr(18'h01233, 18'h1E1E1, 4'h1, 3'b010);
      mem[3] = 18'h1E1E1;
      u_host.drive(1'b0, 1'b0, 1'b1, 3'b010, 4'h7, 18'h01230, 18'h0);
      wr(18'h01231, 18'h0, 4'h7, 3'b000);
      u_host.drive(1'b0, 1'b1, 1'b1, 3'b110, 4'h7, 18'h01232, 18'h0);
      u_host.idle();
      linear_order = 1'b1;
      rd(18'h01230, 4, 1'b0);
      rd(18'h01232, 1, 1'b1);
      end_sim();
   end
   // About 60 cycles are needed; this cuts a hang short
   initial begin
      #(3000 * 50);
      miscompares++;
      end_sim();
   end
endmodule
